/* File: down_timer_pkg.sv */
package down_timer_pkg;

  // ---------------------------------------------------------------
  // register map, byte addresses
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_LOAD = 8'h00;
  localparam logic [7:0] OFF_VALUE = 8'h04;
  localparam logic [7:0] OFF_CONTROL = 8'h08;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h0C;
  localparam logic [7:0] OFF_RAW_IRQ = 8'h10;
  localparam logic [7:0] OFF_MASKED_IRQ = 8'h14;
  localparam logic [7:0] OFF_DEFERRED = 8'h18;

  // ---------------------------------------------------------------
  // control field positions
  // ---------------------------------------------------------------
  localparam int BIT_RUN = 7;
  localparam int BIT_RELOAD_SELECT = 6;
  localparam int BIT_IRQ_MASK = 5;
  localparam int BIT_PRESCALE_HI = 3;
  localparam int BIT_PRESCALE_LO = 2;
  localparam int BIT_WIDTH_SELECT = 1;
  localparam int BIT_SINGLE_PASS = 0;
  localparam logic [7:0] CONTROL_WMASK = 8'hEF;

  // ---------------------------------------------------------------
  // reset values and encodings
  // ---------------------------------------------------------------
  localparam logic [7:0] CONTROL_RESET = 8'h20;
  localparam logic [31:0] LOAD_RESET = 32'h0000_0000;
  localparam logic [31:0] COUNT_RESET = 32'hFFFF_FFFF;
  localparam logic [1:0] PRESCALE_DIV1 = 2'h0;
  localparam logic [1:0] PRESCALE_DIV16 = 2'h1;
  localparam logic [3:0] DIV16_LAST = 4'hF;
  localparam logic [7:0] DIV256_LAST = 8'hFF;
  localparam logic [15:0] HALF_ZERO = 16'h0000;

  // bus request carried as one bundle
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;

endpackage : down_timer_pkg

/* File: dual_down_counter_timer.sv */
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module dual_down_counter_timer
  import down_timer_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // count qualifier
  input wire logic count_clock_qualifier,
  // register bus
  input wire bus_req_type bus,
  output logic [31:0] rdata,
  // interrupt
  output logic channel_irq_out
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0] ctrl;
  logic [31:0] reload_value_reg;
  logic [31:0] pend_value;
  logic pend;
  logic [31:0] count;
  logic [7:0] pcount;
  logic raw_flag;

  logic qual;
  logic run;
  logic periodic;
  logic single;
  logic wide;
  logic tick;
  logic at_zero;
  logic step;
  logic [31:0] dec_value;
  logic [31:0] next_count;
  logic ev;
  logic next_raw;
  logic next_mask;
  logic [31:0] view;
  logic wr_load;
  logic wr_bg;
  logic wr_ctrl;
  logic wr_clr;

  // zero test on the active width; upper half ignored when narrow
  function automatic logic hit_zero(input logic [31:0] v, input logic w);
    hit_zero = w ? (v == LOAD_RESET) : (v[15:0] == HALF_ZERO);
  endfunction : hit_zero

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  assign qual = count_clock_qualifier;
  assign wr_load = bus.wr && (bus.addr == OFF_LOAD);
  assign wr_bg = bus.wr && (bus.addr == OFF_DEFERRED);
  assign wr_ctrl = bus.wr && (bus.addr == OFF_CONTROL);
  assign wr_clr = bus.wr && (bus.addr == OFF_IRQ_CLEAR);
  assign run = ctrl[BIT_RUN];
  assign single = ctrl[BIT_SINGLE_PASS];
  assign periodic = ctrl[BIT_RELOAD_SELECT] && !single;
  assign wide = ctrl[BIT_WIDTH_SELECT];

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  // reserved bit 4 is kept at zero so it reads back zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= CONTROL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= bus.wdata[7:0] & CONTROL_WMASK;
    end
  end

  // ---------------------------------------------------------------
  // load and deferred load
  // ---------------------------------------------------------------
  // both writes land in the load register; only a direct write is
  // queued for the counter, so a deferred write never disturbs it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reload_value_reg <= LOAD_RESET;
    end else if (wr_load || wr_bg) begin
      reload_value_reg <= bus.wdata;
    end
  end

  // pending direct load; a new write wins over the apply edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend <= 1'b0;
      pend_value <= LOAD_RESET;
    end else if (wr_load) begin
      pend <= 1'b1;
      pend_value <= bus.wdata;
    end else if (qual) begin
      pend <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // prescaler
  // ---------------------------------------------------------------
  // runs only on qualified edges; restarted by a load so the first
  // interval after a load is whole
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pcount <= 8'h00;
    end else if (qual) begin
      pcount <= pend ? 8'h00 : pcount + 8'h01;
    end
  end

  // code 11 is undefined; it falls to the slowest rate
  always_comb begin
    case (ctrl[BIT_PRESCALE_HI:BIT_PRESCALE_LO])
      PRESCALE_DIV1: tick = 1'b1;
      PRESCALE_DIV16: tick = (pcount[3:0] == DIV16_LAST);
      default: tick = (pcount == DIV256_LAST);
    endcase
  end

  // ---------------------------------------------------------------
  // counter next value
  // ---------------------------------------------------------------
  assign at_zero = hit_zero(count, wide);
  // one-shot sits at zero until reprogrammed
  assign step = qual && run && tick && !(single && at_zero);

  always_comb begin
    // narrow decrement leaves the upper half untouched; loads and reloads write all 32 bits
    if (wide) begin
      dec_value = count - 32'h0000_0001;
    end else begin
      dec_value = {count[31:16], count[15:0] - 16'h0001};
    end
    next_count = count;
    ev = 1'b0;
    if (qual && pend) begin
      next_count = pend_value;
      ev = hit_zero(pend_value, wide);
    end else if (step) begin
      ev = hit_zero(dec_value, wide);
      if (periodic && ev) begin
        next_count = reload_value_reg;
      end else begin
        next_count = dec_value;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= COUNT_RESET;
    end else begin
      count <= next_count;
    end
  end

  // ---------------------------------------------------------------
  // interrupt flag and output
  // ---------------------------------------------------------------
  // a zero event in the clearing cycle survives the clear
  assign next_raw = ev || (raw_flag && !wr_clr);
  assign next_mask = wr_ctrl ? bus.wdata[BIT_IRQ_MASK] : ctrl[BIT_IRQ_MASK];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      raw_flag <= 1'b0;
    end else begin
      raw_flag <= next_raw;
    end
  end

  // registered from next values so output always equals flag and mask
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      channel_irq_out <= 1'b0;
    end else begin
      channel_irq_out <= next_raw && next_mask;
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  // a queued load shows at once, ahead of the counter edge
  assign view = pend ? pend_value : count;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 32'h0000_0000;
    end else if (bus.rd) begin
      case (bus.addr)
        OFF_LOAD: rdata <= reload_value_reg;
        OFF_DEFERRED: rdata <= reload_value_reg;
        OFF_VALUE: rdata <= view;
        OFF_CONTROL: rdata <= {24'h00_0000, ctrl};
        OFF_RAW_IRQ: rdata <= {31'h0, raw_flag};
        OFF_MASKED_IRQ: rdata <= {31'h0, channel_irq_out};
        default: rdata <= 32'h0000_0000;
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_load_write;
    bus.wr && bus.addr == OFF_LOAD;
  endsequence

  sequence s_clear_write;
    bus.wr && bus.addr == OFF_IRQ_CLEAR && !ev;
  endsequence

  property p_freeze;
    @(posedge clk) disable iff (!rstn)
    (!run && !pend) |=> (count == $past(count));
  endproperty
  a_freeze: assert property (p_freeze) else $error("count moved while stopped");

  property p_decrement;
    @(posedge clk) disable iff (!rstn)
    (step && !pend && wide && !ev) |=> (count == $past(count) - 32'h0000_0001);
  endproperty
  a_decrement: assert property (p_decrement) else $error("missed decrement");

  property p_load_apply;
    @(posedge clk) disable iff (!rstn)
    s_load_write ##1 qual |=> (count == $past(pend_value));
  endproperty
  a_load_apply: assert property (p_load_apply) else $error("load not applied");

  property p_irq_set;
    @(posedge clk) disable iff (!rstn)
    ev |=> raw_flag;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("raw flag not set");

  property p_clear;
    @(posedge clk) disable iff (!rstn)
    s_clear_write |=> (!channel_irq_out && !raw_flag);
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not drop irq");

  property p_mask;
    @(posedge clk) disable iff (!rstn)
    channel_irq_out == (raw_flag && ctrl[BIT_IRQ_MASK]);
  endproperty
  a_mask: assert property (p_mask) else $error("irq output not flag and mask");

  property p_halt;
    @(posedge clk) disable iff (!rstn)
    (single && at_zero && !pend && !wr_load && !wr_ctrl) |=> at_zero;
  endproperty
  a_halt: assert property (p_halt) else $error("one-shot left zero");

  property p_reload;
    @(posedge clk) disable iff (!rstn)
    (step && !pend && periodic && ev) |=> (count == $past(reload_value_reg));
  endproperty
  a_reload: assert property (p_reload) else $error("periodic reload wrong");

  property p_wrap;
    @(posedge clk) disable iff (!rstn)
    (step && !pend && !single && !periodic && wide && count == LOAD_RESET)
      |=> (count == COUNT_RESET);
  endproperty
  a_wrap: assert property (p_wrap) else $error("free-running wrap wrong");

  property p_readback;
    @(posedge clk) disable iff (!rstn)
    (bus.rd && bus.addr == OFF_VALUE) |=> (rdata == $past(view));
  endproperty
  a_readback: assert property (p_readback) else $error("value readback wrong");

  property p_prescale;
    @(posedge clk) disable iff (!rstn)
    (ctrl[BIT_PRESCALE_HI:BIT_PRESCALE_LO] == PRESCALE_DIV16 && tick)
      |-> (pcount[3:0] == DIV16_LAST);
  endproperty
  a_prescale: assert property (p_prescale) else $error("divide 16 tick wrong");

  property p_zero_load;
    @(posedge clk) disable iff (!rstn)
    (qual && pend && pend_value == LOAD_RESET) |=> raw_flag;
  endproperty
  a_zero_load: assert property (p_zero_load) else $error("zero load no irq");

  // a raw flag rise must trace back to an edge where the qualifier was high
  property p_irq_timed;
    @(posedge clk) disable iff (!rstn)
    $rose(raw_flag) |-> $past(qual);
  endproperty
  a_irq_timed: assert property (p_irq_timed) else $error("irq not from qualified edge");

  // without the qualifier nothing moves, not even a queued load
  property p_idle_hold;
    @(posedge clk) disable iff (!rstn)
    !qual |=> (count == $past(count));
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("count moved on idle edge");

  // narrow counting never touches the upper half outside a reload
  property p_narrow_upper;
    @(posedge clk) disable iff (!rstn)
    (!wide && !pend && !ev) |=> (count[31:16] == $past(count[31:16]));
  endproperty
  a_narrow_upper: assert property (p_narrow_upper) else $error("upper half changed");

  property p_wrap_narrow;
    @(posedge clk) disable iff (!rstn)
    (step && !pend && !single && !periodic && !wide && count[15:0] == HALF_ZERO)
      |=> (count[15:0] == COUNT_RESET[15:0]);
  endproperty
  a_wrap_narrow: assert property (p_wrap_narrow) else $error("narrow wrap wrong");

  // a deferred write lands in the load register and queues nothing
  property p_deferred;
    @(posedge clk) disable iff (!rstn)
    (wr_bg && !pend) |=> (!pend && reload_value_reg == $past(bus.wdata));
  endproperty
  a_deferred: assert property (p_deferred) else $error("deferred write disturbed count");

  // the zero step of a one-shot leaves it parked with no further steps
  property p_one_shot_stop;
    @(posedge clk) disable iff (!rstn)
    (step && !pend && single && ev && !wr_ctrl) |=> (at_zero && !step);
  endproperty
  a_one_shot_stop: assert property (p_one_shot_stop) else $error("one-shot kept going");

  // slowest rate: the tick edge must roll the prescaler back to zero
  property p_div256;
    @(posedge clk) disable iff (!rstn)
    (qual && !pend && tick && ctrl[BIT_PRESCALE_HI:BIT_PRESCALE_LO] != PRESCALE_DIV1
      && ctrl[BIT_PRESCALE_HI:BIT_PRESCALE_LO] != PRESCALE_DIV16) |=> (pcount == 8'h00);
  endproperty
  a_div256: assert property (p_div256) else $error("divide 256 tick wrong");

  // status reads return the flag as it stood on the strobe cycle
  property p_raw_readback;
    @(posedge clk) disable iff (!rstn)
    (bus.rd && bus.addr == OFF_RAW_IRQ) |=> (rdata == {31'h0, $past(raw_flag)});
  endproperty
  a_raw_readback: assert property (p_raw_readback) else $error("raw status wrong");

  property p_masked_readback;
    @(posedge clk) disable iff (!rstn)
    (bus.rd && bus.addr == OFF_MASKED_IRQ)
      |=> (rdata == {31'h0, $past(raw_flag) & $past(ctrl[BIT_IRQ_MASK])});
  endproperty
  a_masked_readback: assert property (p_masked_readback) else $error("masked status wrong");

endmodule : dual_down_counter_timer

`default_nettype wire

/* File: bus_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// processor side of the register bus
module bus_host_model
  import down_timer_pkg::*;
(
  // clock
  input wire logic clk,
  // register bus
  output var bus_req_type bus,
  input wire logic [31:0] rdata
);
  initial bus = '0;

  // one write cycle; released fields go inverted so stale values never pass as live
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    x = d;
    if (a == OFF_CONTROL && d[3:2] == 2'h3) x[3] = 1'b0;
    @(posedge clk);
    bus.addr <= a;
    bus.wdata <= x;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
    bus.addr <= ~a;
    bus.wdata <= ~x;
  endtask : wr_reg

  // one read cycle; data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    bus.addr <= ~a;
    #1 d = rdata;
  endtask : rd_reg
endmodule : bus_host_model
`default_nettype wire

/* File: dual_down_counter_timer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module dual_down_counter_timer_tb
  import down_timer_pkg::*;
;
  logic clk;
  logic rstn;
  logic count_clock_qualifier;
  logic toggle;
  bus_req_type bus;
  logic [31:0] rdata;
  logic channel_irq_out;
  logic irq_q;
  logic [31:0] v;
  logic [31:0] w;
  logic [31:0] ld;
  logic [15:0] up;
  logic [7:0] ra [6];
  logic [31:0] re [6];
  time rises[$];
  int n_fail;
  int checked;

  dual_down_counter_timer DUT (.clk(clk), .rstn(rstn),
    .count_clock_qualifier(count_clock_qualifier), .bus(bus), .rdata(rdata),
    .channel_irq_out(channel_irq_out));
  bus_host_model host (.clk(clk), .bus(bus), .rdata(rdata));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // qualifier on every second edge while toggle is set; irq rise times kept
  always @(posedge clk) begin
    count_clock_qualifier <= toggle ? ~count_clock_qualifier : 1'b1;
    irq_q <= channel_irq_out;
    if (channel_irq_out && !irq_q) rises.push_back($time);
  end

  function automatic logic [31:0] ctl(logic run, logic per, logic msk, logic [1:0] pre,
    logic w32, logic one);
    return {24'h00_0000, run, per, msk, 1'b0, pre, w32, one};
  endfunction : ctl

  // decrements expected over cyc edges
  function automatic logic [31:0] ticks(int cyc, logic [1:0] pre, logic tq);
    return (cyc >> (tq ? 1 : 0)) >> (pre * 4);
  endfunction : ticks

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic end_of_test;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  // bounded wait for the irq level
  task automatic wait_irq(logic lvl, int lim);
    int n;
    n = 0;
    // step off the edge so a value launched there is already settled
    #1;
    while (channel_irq_out !== lvl && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    check({31'h0, channel_irq_out}, {31'h0, lvl});
  endtask : wait_irq

  // three irqs, each cleared; last spacing must be cyc clocks
  task automatic periods(int cyc);
    repeat (3) begin
      wait_irq(1'b1, 5000);
      host.wr_reg(OFF_IRQ_CLEAR, $urandom);
      wait_irq(1'b0, 3);
    end
    check(32'(rises[$] - rises[$-1]), 32'(cyc * 20));
  endtask : periods

  // watchdog, far beyond the expected run
  initial begin
    #1_000_000;
    n_fail++;
    end_of_test();
  end

  initial begin
    rstn = 1'b0;
    toggle = 1'b0;
    n_fail = 0;
    checked = 0;
    ra = '{OFF_LOAD, OFF_VALUE, OFF_CONTROL, OFF_RAW_IRQ, OFF_MASKED_IRQ, 8'h1C};
    re = '{32'h0, 32'hFFFF_FFFF, ctl(0, 0, 1, 2'h0, 0, 0), 32'h0, 32'h0, 32'h0};
    void'($urandom(21));
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    // reset values; the unmapped place reads zero
    foreach (ra[i]) begin
      host.rd_reg(ra[i], v);
      check(v, re[i]);
    end
    $display("test reset done");
    // rate for prescale codes 0 to 2, steady and pulsed qualifier
    for (int p = 0; p < 3; p++) begin
      for (int t = 0; t < 2; t++) begin
        toggle <= t[0];
        ld = $urandom | 32'h8000_8000;
        host.wr_reg(OFF_LOAD, ld);
        host.wr_reg(OFF_CONTROL, ctl(1, 0, 1, p[1:0], 1, 0));
        host.rd_reg(OFF_VALUE, v);
        check(v[31:16], ld[31:16]);
        repeat (510) @(posedge clk);
        host.rd_reg(OFF_VALUE, w);
        check(v - w, ticks(512, p[1:0], t[0]));
      end
    end
    // freeze holds the count, resume goes on from it
    toggle <= 1'b0;
    host.wr_reg(OFF_CONTROL, ctl(0, 0, 1, 2'h0, 1, 0));
    host.rd_reg(OFF_VALUE, v);
    repeat (40) @(posedge clk);
    host.rd_reg(OFF_VALUE, w);
    check(w, v);
    host.wr_reg(OFF_CONTROL, ctl(1, 0, 1, 2'h0, 1, 0));
    host.rd_reg(OFF_VALUE, w);
    check(32'(v - w inside {[1:7]}), 32'h1);
    $display("test rate done");
    // free-running zero in both widths; 16-bit keeps the upper half
    for (int k = 0; k < 2; k++) begin
      up = 16'($urandom);
      ld = k ? 32'h0000_0010 : {up, 16'h0010};
      host.wr_reg(OFF_LOAD, ld);
      host.wr_reg(OFF_CONTROL, ctl(1, 0, 1, 2'h0, k[0], 0));
      wait_irq(1'b1, 40);
      host.rd_reg(OFF_RAW_IRQ, v);
      check(v, 32'h1);
      host.rd_reg(OFF_MASKED_IRQ, v);
      check(v, 32'h1);
      host.rd_reg(OFF_VALUE, v);
      check(v[31:12], {k ? 16'hFFFF : up, 4'hF});
      host.wr_reg(OFF_IRQ_CLEAR, $urandom);
      wait_irq(1'b0, 2);
    end
    $display("test wrap done");
    // periodic spacing; deferred value waits for the next zero
    for (int p = 0; p < 2; p++) begin
      ld = 5 + $urandom_range(7);
      host.wr_reg(OFF_LOAD, ld);
      host.wr_reg(OFF_CONTROL, ctl(1, 1, 1, p[1:0], 1, 0));
      periods(ld << (4 * p));
      host.wr_reg(OFF_DEFERRED, ld + 3);
      host.rd_reg(OFF_VALUE, v);
      check(32'(v <= ld), 32'h1);
      host.rd_reg(OFF_LOAD, v);
      check(v, ld + 3);
      periods((ld + 3) << (4 * p));
    end
    $display("test periodic done");
    // one-shot with mask off, then on; reload select set but ignored in the mask-off pass
    host.wr_reg(OFF_CONTROL, ctl(1, 1, 0, 2'h0, 1, 1));
    host.wr_reg(OFF_IRQ_CLEAR, 32'h0);
    host.wr_reg(OFF_LOAD, 32'h0000_0006);
    repeat (20) @(posedge clk);
    host.rd_reg(OFF_RAW_IRQ, v);
    check(v, 32'h1);
    host.rd_reg(OFF_MASKED_IRQ, w);
    check(w, 32'h0);
    check({31'h0, channel_irq_out}, 32'h0);
    host.rd_reg(OFF_VALUE, v);
    check(v, 32'h0);
    host.wr_reg(OFF_LOAD, 32'h0000_0090);
    host.rd_reg(OFF_VALUE, v);
    check(32'(v inside {[32'h80:32'h90]}), 32'h1);
    host.wr_reg(OFF_CONTROL, ctl(1, 0, 1, 2'h0, 1, 1));
    wait_irq(1'b1, 3);
    host.wr_reg(OFF_IRQ_CLEAR, 32'h0);
    wait_irq(1'b0, 2);
    host.wr_reg(OFF_LOAD, 32'h0);
    wait_irq(1'b1, 4);
    $display("test one-shot done");
    end_of_test();
  end
endmodule : dual_down_counter_timer_tb
`default_nettype wire
